/* File: hdl/pst_pkg.sv */
// Package with command codes, field layout, carriers and state of the status/telemetry block
package pst_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_OTHER_STATUS = 8'h7f;
  localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
  localparam logic [7:0] CMD_INPUT_VOLTAGE = 8'h88;
  localparam logic [7:0] CMD_OUTPUT_VOLTAGE = 8'h8b;
  localparam logic [7:0] PHASE_ALL = 8'hff;

  // ----------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------
  localparam int OTHER_FIRST_BIT = 0;
  localparam int VEN_POR_BIT = 7;
  localparam int VEN_SELF_BIT = 6;
  localparam int VEN_RESET_BIT = 3;
  localparam int VEN_BCX_BIT = 2;
  localparam int VEN_SYNC_BIT = 1;
  localparam int CML_INVALID_BIT = 7;
  localparam logic [7:0] VEN_LATCH_MASK = 8'h8e;

  // ----------------------------------------------------------------
  // Counts and byte positions
  // ----------------------------------------------------------------
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam logic [1:0] BYTE_ADDR = 2'h0;
  localparam logic [1:0] BYTE_CMD = 2'h1;
  localparam logic [1:0] BYTE_DATA = 2'h2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic first_to_alert;
    logic por_fault;
    logic self_check_busy;
    logic output_reset_event;
    logic back_channel_link_fault;
    logic sync_fault;
    logic clear_faults;
    logic cml_invalid_clear;
  } pst_events_s;

  typedef struct packed {
    logic [7:0] phase;
    logic loop_follower;
    logic refresh;
    logic [15:0] controller_vin;
    logic [15:0] phase_vin;
    logic [15:0] vout_scaled;
    logic [15:0] remote_sense_raw;
  } pst_tele_s;

  typedef struct packed {
    logic [7:0] other;
    logic [7:0] vendor;
    logic [7:0] cml;
  } pst_mask_s;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TX_ACK} pst_bus_e;

  typedef struct packed {
    pst_bus_e st;
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [1:0] byte_idx;
    logic rw;
    logic mack;
    logic tx_idx;
    logic [7:0] cmd;
    logic sda_drv;
    logic other_first;
    logic [7:0] vendor;
    logic inv_flag;
    logic comm_set;
    logic read_busy;
    logic [15:0] vin_hold;
    logic [15:0] vout_hold;
    logic alert;
  } pst_state_s;

  // Pin copies start at the idle bus level so no false edge follows reset
  localparam pst_state_s PST_STATE_RESET = '{st: ST_IDLE, scl_q: 1'b1, sda_q: 1'b1, default: '0};

endpackage

/* File: hdl/pst_sync.sv */
// Two-flop synchroniser for the bus pins
`timescale 1ns/10ps
module pst_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------
  // Per-bit flop pair
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      logic meta_reg;
      logic stable_reg;
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          meta_reg <= 1'b1;
          stable_reg <= 1'b1;
        end else begin
          meta_reg <= async_in[i];
          stable_reg <= meta_reg;
        end
      end
      assign sync_out[i] = stable_reg;
    end
  endgenerate

endmodule

/* File: hdl/pst_regs.sv */
// Status and telemetry command registers with their bus target logic
//
// Summary of operation
// - Code 7F is a byte status, read and write, bits 7:1 read zero.
// - Bit 0 latches when this unit first pulled the alert line.
// - Other summary bit is the OR of supported other-status bits.
// - Clearing the other-status byte also clears its summary bit.
// - Code 80 is a byte status; latched bits clear by clear-faults or write-one.
// - Bit 7 latches on trim, store checksum or strap check failure.
// - Bit 6 is live: high while self-check runs or followers missing.
// - Bits 3, 2, 1 latch output reset, back-channel fault, sync fault.
// - Bits 5:4 and 0 of the vendor status always read zero.
// - Writing one to a set latched status bit clears it.
// - Each alerting status bit has a mask bit that suppresses the alert.
// - Code 88 reads input voltage word, exponent 15:11, mantissa 10:0.
// - Writes to telemetry codes set comm summary, invalid flag, and alert.
// - Phase FF gives controller input voltage, else the phase's device.
// - Code 8B reads the output voltage as an unsigned 16-bit word.
// - As loop follower, output reading is raw sense voltage, no scaling.
// - Invalid-command flag at bit 7 latches, clears on the cml_invalid_clear input or clear-faults.
`timescale 1ns/10ps
module pst_regs (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [6:0] device_address_in,
  input wire pst_pkg::pst_events_s events_in,
  input wire pst_pkg::pst_tele_s tele_in,
  input wire pst_pkg::pst_mask_s mask_in,
  output logic [7:0] other_status_out,
  output logic [7:0] vendor_status_out,
  output logic other_summary_out,
  output logic comm_summary_out,
  output logic invalid_command_out,
  output logic invalid_command_flag_out,
  output logic alert_out,
  output logic [15:0] input_voltage_out,
  output logic [15:0] output_voltage_out
);
  import pst_pkg::*;

  pst_state_s state_reg;
  pst_state_s state_next;
  logic [1:0] pins_sync;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] other_byte;
  logic [7:0] vendor_byte;
  logic [15:0] tx_word;
  logic [7:0] tx_byte;
  logic [7:0] tx_byte_next;
  logic [15:0] vin_source;
  logic [15:0] vout_source;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  pst_sync #(.WIDTH(2)) u_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .async_in({scl_in, sda_in}),
    .sync_out(pins_sync)
  );

  // ----------------------------------------------------------------
  // Bus conditions
  // ----------------------------------------------------------------
  assign scl_s = pins_sync[1];
  assign sda_s = pins_sync[0];
  assign scl_rise = scl_s & ~state_reg.scl_q;
  assign scl_fall = ~scl_s & state_reg.scl_q;
  assign bus_start = scl_s & state_reg.scl_q & state_reg.sda_q & ~sda_s;
  assign bus_stop = scl_s & state_reg.scl_q & ~state_reg.sda_q & sda_s;

  // ----------------------------------------------------------------
  // Read values
  // ----------------------------------------------------------------
  assign other_byte = {7'h00, state_reg.other_first};

  // ----------------------------------------------------------------
  // Vendor status read bits
  // ----------------------------------------------------------------
  genvar vb;
  generate
    for (vb = 0; vb < 8; vb = vb + 1) begin : g_ven_bit
      if (vb == VEN_SELF_BIT) begin : g_live
        assign vendor_byte[vb] = events_in.self_check_busy;
      end else begin : g_held
        assign vendor_byte[vb] = state_reg.vendor[vb] & VEN_LATCH_MASK[vb];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Telemetry sources
  // ----------------------------------------------------------------
  assign vin_source = (tele_in.phase == PHASE_ALL) ? tele_in.controller_vin
                                                   : tele_in.phase_vin;
  assign vout_source = tele_in.loop_follower ? tele_in.remote_sense_raw
                                             : tele_in.vout_scaled;

  // ----------------------------------------------------------------
  // Transmit word
  // ----------------------------------------------------------------
  always_comb begin
    case (state_reg.cmd)
      CMD_OTHER_STATUS: tx_word = {8'h00, other_byte};
      CMD_VENDOR_STATUS: tx_word = {8'h00, vendor_byte};
      CMD_INPUT_VOLTAGE: tx_word = state_reg.vin_hold;
      CMD_OUTPUT_VOLTAGE: tx_word = state_reg.vout_hold;
      default: tx_word = 16'h0000;
    endcase
  end

  // Low byte first, as the word read sends it
  assign tx_byte = tx_word[7:0];
  assign tx_byte_next = tx_word[15:8];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic w1c_other;
    logic [7:0] w1c_vendor;
    logic [7:0] set_vendor;
    logic clear_all;
    logic alert_other;
    logic alert_vendor;
    logic alert_cml;
    w1c_other = 1'b0;
    w1c_vendor = 8'h00;
    set_vendor = 8'h00;
    clear_all = events_in.clear_faults;
    alert_other = 1'b0;
    alert_vendor = 1'b0;
    alert_cml = 1'b0;
    state_next = state_reg;
    state_next.scl_q = scl_s;
    state_next.sda_q = sda_s;
    state_next.comm_set = 1'b0;

    case (state_reg.st)
      ST_IDLE: begin
        state_next.sda_drv = 1'b0;
      end
      ST_RX: begin
        if (scl_rise && state_reg.bit_cnt != BITS_PER_BYTE) begin
          state_next.shift = {state_reg.shift[6:0], sda_s};
          state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
        end
        if (scl_fall && state_reg.bit_cnt == BITS_PER_BYTE) begin
          state_next.st = ST_ACK;
          state_next.sda_drv = 1'b1;
          if (state_reg.byte_idx != BYTE_DATA) begin
            state_next.byte_idx = state_reg.byte_idx + 2'h1;
          end
          case (state_reg.byte_idx)
            BYTE_ADDR: begin
              state_next.rw = state_reg.shift[0];
              state_next.tx_idx = 1'b0;
              if (state_reg.shift[7:1] != device_address_in) begin
                state_next.st = ST_IDLE;
                state_next.sda_drv = 1'b0;
              end
            end
            BYTE_CMD: begin
              state_next.cmd = state_reg.shift;
              state_next.read_busy = (state_reg.shift == CMD_INPUT_VOLTAGE) ||
                                     (state_reg.shift == CMD_OUTPUT_VOLTAGE);
            end
            default: begin
              case (state_reg.cmd)
                CMD_OTHER_STATUS: w1c_other = state_reg.shift[OTHER_FIRST_BIT];
                CMD_VENDOR_STATUS: w1c_vendor = state_reg.shift & VEN_LATCH_MASK;
                CMD_INPUT_VOLTAGE: state_next.comm_set = 1'b1;
                CMD_OUTPUT_VOLTAGE: state_next.comm_set = 1'b1;
                default: state_next.comm_set = 1'b0;
              endcase
            end
          endcase
        end
      end
      ST_ACK: begin
        if (scl_fall) begin
          state_next.bit_cnt = 4'h0;
          if (state_reg.rw) begin
            state_next.st = ST_TX;
            state_next.shift = tx_byte;
            state_next.sda_drv = ~tx_byte[7];
          end else begin
            state_next.st = ST_RX;
            state_next.sda_drv = 1'b0;
          end
        end
      end
      ST_TX: begin
        if (scl_fall) begin
          if (state_reg.bit_cnt == LAST_TX_BIT) begin
            state_next.st = ST_TX_ACK;
            state_next.sda_drv = 1'b0;
          end else begin
            state_next.shift = {state_reg.shift[6:0], 1'b0};
            state_next.sda_drv = ~state_reg.shift[6];
            state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
          end
        end
      end
      ST_TX_ACK: begin
        if (scl_rise) begin
          state_next.mack = ~sda_s;
        end
        if (scl_fall) begin
          state_next.bit_cnt = 4'h0;
          if (state_reg.mack) begin
            state_next.st = ST_TX;
            state_next.tx_idx = 1'b1;
            state_next.shift = state_reg.tx_idx ? 8'h00 : tx_byte_next;
            state_next.sda_drv = state_reg.tx_idx ? 1'b1 : ~tx_byte_next[7];
          end else begin
            state_next.st = ST_IDLE;
            state_next.sda_drv = 1'b0;
          end
        end
      end
      default: begin
        state_next.st = ST_IDLE;
        state_next.sda_drv = 1'b0;
      end
    endcase

    // Start (also repeated) and stop override the byte machine
    if (bus_start) begin
      state_next.st = ST_RX;
      state_next.bit_cnt = 4'h0;
      state_next.byte_idx = BYTE_ADDR;
      state_next.sda_drv = 1'b0;
      state_next.mack = 1'b0;
    end
    if (bus_stop) begin
      state_next.st = ST_IDLE;
      state_next.sda_drv = 1'b0;
      state_next.read_busy = 1'b0;
    end

    // Latched status, set wins over clear
    set_vendor[VEN_POR_BIT] = events_in.por_fault;
    set_vendor[VEN_RESET_BIT] = events_in.output_reset_event;
    set_vendor[VEN_BCX_BIT] = events_in.back_channel_link_fault;
    set_vendor[VEN_SYNC_BIT] = events_in.sync_fault;
    state_next.other_first = (state_reg.other_first & ~w1c_other & ~clear_all) |
                             events_in.first_to_alert;
    state_next.vendor = ((state_reg.vendor & ~w1c_vendor & ~{8{clear_all}}) |
                         set_vendor) & VEN_LATCH_MASK;
    state_next.inv_flag = (state_reg.inv_flag & ~events_in.cml_invalid_clear &
                           ~clear_all) | state_next.comm_set;

    // Telemetry capture, frozen while a word read is open
    if (tele_in.refresh && !state_reg.read_busy) begin
      state_next.vin_hold = vin_source;
      state_next.vout_hold = vout_source;
    end

    // Alert request, each source gated by its mask bit
    alert_other = state_next.other_first & ~mask_in.other[OTHER_FIRST_BIT];
    alert_vendor = |(state_next.vendor & ~mask_in.vendor);
    alert_cml = state_next.inv_flag & ~mask_in.cml[CML_INVALID_BIT];
    state_next.alert = alert_other | alert_vendor | alert_cml;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_reg <= PST_STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sda_out = 1'b0;
  assign sda_oe_out = state_reg.sda_drv;
  assign other_status_out = other_byte;
  assign vendor_status_out = vendor_byte;
  assign other_summary_out = |other_byte;
  assign comm_summary_out = state_reg.inv_flag;
  assign invalid_command_out = state_reg.comm_set;
  assign invalid_command_flag_out = state_reg.inv_flag;
  assign alert_out = state_reg.alert;
  assign input_voltage_out = state_reg.vin_hold;
  assign output_voltage_out = state_reg.vout_hold;

endmodule

/* File: sim/pst_regs_checker.sv */
// Port checker for the status and telemetry registers
`timescale 1ns/10ps
module pst_regs_checker (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire pst_pkg::pst_events_s events_in,
  input wire pst_pkg::pst_tele_s tele_in,
  input wire pst_pkg::pst_mask_s mask_in,
  input wire logic [7:0] other_status_out,
  input wire logic [7:0] vendor_status_out,
  input wire logic other_summary_out,
  input wire logic comm_summary_out,
  input wire logic invalid_command_out,
  input wire logic invalid_command_flag_out,
  input wire logic alert_out,
  input wire logic [15:0] input_voltage_out,
  input wire logic [15:0] output_voltage_out
);
  import pst_pkg::*;
  // --------
  // Assertions
  // --------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  AST_OTHER_RSV: assert property (other_status_out[7:1] == 7'h00)
    else $error("other status reserved bits set");
  AST_FIRST: assert property (events_in.first_to_alert |=> other_status_out[OTHER_FIRST_BIT])
    else $error("first-to-alert not latched");
  AST_OTHER_SUM: assert property (other_summary_out == (|other_status_out))
    else $error("other summary differs from other status");
  AST_POR: assert property (events_in.por_fault |=> vendor_status_out[VEN_POR_BIT])
    else $error("power-on fault not latched");
  AST_SELF: assert property (vendor_status_out[VEN_SELF_BIT] == events_in.self_check_busy)
    else $error("self-check bit not live");
  AST_RESET_EVT: assert property (events_in.output_reset_event |=> vendor_status_out[3])
    else $error("output reset event not latched");
  AST_BCX_EVT: assert property (events_in.back_channel_link_fault |=> vendor_status_out[2])
    else $error("back-channel fault not latched");
  AST_SYNC_EVT: assert property (events_in.sync_fault |=> vendor_status_out[VEN_SYNC_BIT])
    else $error("sync fault not latched");
  AST_VEN_RSV: assert property ((vendor_status_out & 8'h31) == 8'h00)
    else $error("vendor status reserved bits set");
  AST_CLEAR: assert property (events_in.clear_faults && !(events_in.por_fault
    || events_in.output_reset_event || events_in.back_channel_link_fault
    || events_in.sync_fault) |=> (vendor_status_out & VEN_LATCH_MASK) == 8'h00)
    else $error("clear faults left vendor bits set");
  AST_COMM_SUM: assert property (comm_summary_out == invalid_command_flag_out)
    else $error("comm summary differs from invalid flag");
  AST_IVC: assert property (invalid_command_out |-> ##[0:1] invalid_command_flag_out)
    else $error("invalid command not flagged");
  AST_ALERT: assert property ((vendor_status_out[7] && !mask_in.vendor[7]) [*2] |-> alert_out)
    else $error("unmasked fault without alert");
  AST_HOLD: assert property (!$past(tele_in.refresh) |-> $stable(input_voltage_out)
    && $stable(output_voltage_out))
    else $error("telemetry changed without refresh");
  CV_IVC: cover property (invalid_command_out);
  CV_VEN: cover property (vendor_status_out == 8'h8e);
  CV_ALERT: cover property (alert_out && other_summary_out);
endmodule

bind pst_regs pst_regs_checker u_chk (.clk_in, .reset_in, .events_in, .tele_in, .mask_in,
  .other_status_out, .vendor_status_out, .other_summary_out, .comm_summary_out,
  .invalid_command_out, .invalid_command_flag_out, .alert_out, .input_voltage_out,
  .output_voltage_out);

/* File: sim/pst_host.sv */
// Bus host model driving the clock and open-drain data line
`timescale 1ns/10ps
module pst_host (
  input wire logic clk_in,
  output logic scl_out,
  output logic sda_low_out,
  input wire logic sda_in
);
  // --------
  // Bit and frame tasks, 80 ns per bit
  // --------
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low_out = !b;
    cyc(4);
    scl_out = 1'b1;
    cyc(3);
    r = sda_in;
    cyc(1);
    scl_out = 1'b0;
    cyc(2);
  endtask
  task automatic start_c();
    sda_low_out = 1'b0;
    cyc(6);
    scl_out = 1'b1;
    cyc(3);
    sda_low_out = 1'b1;
    cyc(3);
    scl_out = 1'b0;
    cyc(2);
  endtask
  task automatic stop_c();
    sda_low_out = 1'b1;
    cyc(6);
    scl_out = 1'b1;
    cyc(3);
    sda_low_out = 1'b0;
    cyc(4);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
                      output logic ak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ai, ak);
  endtask
  task automatic write(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                       output logic ok);
    logic [7:0] rx;
    logic k0, k1, k2;
    start_c();
    xfer({a, 1'b0}, 1'b1, rx, k0);
    xfer(c, 1'b1, rx, k1);
    xfer(d, 1'b1, rx, k2);
    stop_c();
    ok = !(k0 || k1 || k2);
  endtask
  task automatic read(input logic [6:0] a, input logic [7:0] c, output logic [15:0] v,
                      output logic ok);
    logic [7:0] rx;
    logic k0, k1, k2, k3;
    start_c();
    xfer({a, 1'b0}, 1'b1, rx, k0);
    xfer(c, 1'b1, rx, k1);
    start_c();
    xfer({a, 1'b1}, 1'b1, rx, k2);
    xfer(8'hff, 1'b0, v[7:0], k3);
    xfer(8'hff, 1'b1, v[15:8], k3);
    stop_c();
    ok = !(k0 || k1 || k2);
  endtask
endmodule

/* File: sim/pst_regs_tb.sv */
// Self-checking bench for the status and telemetry registers
`timescale 1ns/10ps
module pst_regs_tb;
  import pst_pkg::*;
  logic clk_in, reset_in, scl, sda_low, sda_oe, sda_o, other_sum, comm_sum, invalid_command_flag, ivc_flag;
  logic alert;
  logic [6:0] addr;
  logic [7:0] other_st, vendor_st;
  logic [15:0] vin, vout;
  pst_events_s ev;
  pst_tele_s tele;
  pst_mask_s mask;
  logic [15:0] exp_q[$];
  logic [15:0] obs_q[$];
  string nm_q[$];
  int n_mismatch = 0;
  int comparisons = 0;
  int ivc_cnt = 0;
  wire sda_wire = !(sda_low || (sda_oe && !sda_o));
  pst_regs dut (.clk_in(clk_in), .reset_in(reset_in), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .device_address_in(addr), .events_in(ev),
    .tele_in(tele), .mask_in(mask), .other_status_out(other_st), .vendor_status_out(vendor_st),
    .other_summary_out(other_sum), .comm_summary_out(comm_sum), .invalid_command_out(invalid_command_flag),
    .invalid_command_flag_out(ivc_flag), .alert_out(alert), .input_voltage_out(vin),
    .output_voltage_out(vout));
  pst_host host (.clk_in(clk_in), .scl_out(scl), .sda_low_out(sda_low), .sda_in(sda_wire));
  always @(posedge clk_in) begin
    if (invalid_command_flag) begin
      ivc_cnt <= ivc_cnt + 1;
    end
  end
  // --------
  // Clock, compare process, tasks
  // --------
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  initial begin
    forever begin
      wait (obs_q.size() > 0);
      comparisons++;
      if (obs_q[0] !== exp_q[0]) begin
        n_mismatch++;
        $display("[FAIL] %s expected %h seen %h", nm_q[0], exp_q[0], obs_q[0]);
      end
      void'(obs_q.pop_front());
      void'(exp_q.pop_front());
      void'(nm_q.pop_front());
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] o);
    nm_q.push_back(n);
    exp_q.push_back(e);
    obs_q.push_back(o);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    logic ok;
    host.write(addr, c, d, ok);
    chk("write ack", 16'h0001, {15'h0000, ok});
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e, input string n);
    logic [15:0] v;
    logic ok;
    host.read(addr, c, v, ok);
    chk("read ack", 16'h0001, {15'h0000, ok});
    chk(n, e, v);
  endtask
  task automatic pulse(input pst_events_s e);
    ev = e;
    @(negedge clk_in);
    ev = '0;
    repeat (2) @(negedge clk_in);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_in);
    n_mismatch++;
    finish_test();
  end
  // --------
  // Tests
  // --------
  initial begin
    void'($urandom(32'hc60333a2));
    reset_in = 1'b1;
    ev = 8'h20;
    tele = '0;
    mask = '0;
    addr = 7'($urandom);
    repeat (20) @(negedge clk_in);
    reset_in = 1'b0;
    repeat (3) @(negedge clk_in);
    chk("vendor", 16'h0040, {8'h00, vendor_st});
    chk("other", 16'h0000, {8'h00, other_st});
    ev = '0;
    @(negedge clk_in);
    chk("vendor", 16'h0000, {8'h00, vendor_st});
    $display("test reset done");
    pulse(8'hdc);
    chk("other", 16'h0001, {8'h00, other_st});
    chk("summary", 16'h0001, {15'h0000, other_sum});
    chk("alert", 16'h0001, {15'h0000, alert});
    rd(CMD_OTHER_STATUS, 16'h0001, "other read");
    rd(CMD_VENDOR_STATUS, 16'h008e, "vendor read");
    wr(CMD_VENDOR_STATUS, 8'h0c);
    chk("vendor", 16'h0082, {8'h00, vendor_st});
    wr(CMD_OTHER_STATUS, 8'hff);
    chk("summary", 16'h0000, {7'h00, other_sum, other_st});
    pulse(8'h02);
    chk("vendor", 16'h0000, {8'h00, vendor_st});
    $display("test status done");
    mask.vendor = 8'h80;
    pulse(8'h40);
    chk("masked alert", 16'h0080, {7'h00, alert, vendor_st});
    mask = '0;
    repeat (2) @(negedge clk_in);
    chk("alert", 16'h0001, {15'h0000, alert});
    pulse(8'h02);
    $display("test mask done");
    for (int i = 0; i < 4; i++) begin
      tele.phase = i[0] ? PHASE_ALL : 8'($urandom_range(254));
      tele.loop_follower = i[1];
      tele.controller_vin = 16'($urandom);
      tele.phase_vin = 16'($urandom);
      tele.vout_scaled = 16'($urandom);
      tele.remote_sense_raw = 16'($urandom);
      tele.refresh = 1'b1;
      @(negedge clk_in);
      tele.refresh = 1'b0;
      chk("vin out", i[0] ? tele.controller_vin : tele.phase_vin, vin);
      chk("vout out", i[1] ? tele.remote_sense_raw : tele.vout_scaled, vout);
      rd(CMD_INPUT_VOLTAGE, i[0] ? tele.controller_vin : tele.phase_vin, "vin");
      rd(CMD_OUTPUT_VOLTAGE, i[1] ? tele.remote_sense_raw : tele.vout_scaled, "vout");
    end
    rd(8'h55, 16'h0000, "unmapped");
    $display("test telemetry done");
    wr(CMD_INPUT_VOLTAGE, 8'h5a);
    chk("invalid flag", 16'h0001, {15'h0000, ivc_flag});
    chk("comm summary", 16'h0001, {15'h0000, comm_sum});
    chk("alert", 16'h0001, {15'h0000, alert});
    chk("invalid pulses", 16'h0001, 16'(ivc_cnt));
    pulse(8'h01);
    chk("flag cleared", 16'h0000, {14'h0000, ivc_flag, alert});
    mask.cml = 8'h80;
    wr(CMD_OUTPUT_VOLTAGE, 8'ha5);
    chk("masked flag", 16'h0002, {14'h0000, ivc_flag, alert});
    chk("invalid pulses", 16'h0002, 16'(ivc_cnt));
    pulse(8'h02);
    chk("flag cleared", 16'h0000, {14'h0000, ivc_flag, comm_sum});
    mask = '0;
    $display("test invalid write done");
    wait (obs_q.size() == 0);
    @(negedge clk_in);
    finish_test();
  end
endmodule
